// *** inc/urxbf_pkg.sv ***
// Constants, register map and field positions for the receiver buffer block
package urxbf_pkg;
  // Register bus
  localparam int unsigned ADDR_W        = 2;
  localparam logic [1:0]  OFS_STATUS_A  = 2'h0;
  localparam logic [1:0]  OFS_CONTROL_B = 2'h1;
  localparam logic [1:0]  OFS_CONTROL_C = 2'h2;
  localparam logic [1:0]  OFS_DATA      = 2'h3;
  // status_reg_a bit positions
  localparam int unsigned SA_RXC = 7;
  localparam int unsigned SA_FE  = 4;
  localparam int unsigned SA_DOR = 3;
  localparam int unsigned SA_UPE = 2;
  localparam int unsigned SA_U2X = 1;
  // control_reg_b bit positions
  localparam int unsigned CB_RX_COMPLETE_IRQ_EN = 7;
  localparam int unsigned CB_RX_ENABLE_BIT  = 4;
  localparam int unsigned CB_CSZ2  = 2;
  localparam int unsigned CB_RX_NINTH_BIT  = 1;
  // control_reg_c bit positions
  localparam int unsigned CC_UPM1 = 5;
  localparam int unsigned CC_UPM0 = 4;
  localparam int unsigned CC_STOP_BITS_SELECT = 3;
  localparam int unsigned CC_CSZ1 = 2;
  localparam int unsigned CC_CSZ0 = 1;
  // Frame format
  localparam logic [2:0] CSZ_NINE      = 3'h7;
  localparam logic [3:0] DATA_BITS_MIN = 4'h5;
  localparam logic [3:0] DATA_BITS_NINE = 4'h9;
  // Oversampling: samples per bit and the three voting samples
  localparam logic [4:0] SPB_NORM        = 5'h10;
  localparam logic [4:0] SPB_DBL         = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORM = 5'h08;
  localparam logic [4:0] VOTE_LAST_NORM  = 5'h0a;
  localparam logic [4:0] VOTE_FIRST_DBL  = 5'h04;
  localparam logic [4:0] VOTE_LAST_DBL   = 5'h06;
  localparam logic [1:0] VOTE_MAJORITY   = 2'h2;
  // Receive buffer
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  // Buffer entry: {overrun, parity error, frame error, data[8:0]}
  localparam int unsigned ENT_W   = 12;
  localparam int unsigned ENT_DOR = 11;
  localparam int unsigned ENT_UPE = 10;
  localparam int unsigned ENT_FE  = 9;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} urxbf_state_t;
endpackage

// *** design/urxbf_top.sv ***
// Asynchronous serial receiver with two-entry buffer, status flags and register port
//
// Functional notes
// - Ninth bit, frame, overrun, parity errors travel with each buffered frame.
// - Receive-complete flag is one exactly while the buffer holds unread data.
// - Clearing receiver enable flushes buffer and clears receive-complete.
// - Interrupt request stays high while flag and its enable are both set.
// - Software writes to error flag positions change nothing.
// - Error flags never raise an interrupt.
// - Frame error shows first stop bit of the head frame, one if low.
// - Only the first stop bit is checked; further stop bits ignored.
// - Overrun when buffer full, shift register waiting, new start detected.
// - Overrun indication clears once a frame enters the buffer.
// - Parity error reads zero while parity checking is disabled.
// - Upper parity bit enables checker; lower bit picks odd or even.
// - Checker compares data parity with received parity bit, stored per frame.
// - Parity error only for frames received with checking on; valid until read.
// - Disabling receiver is immediate, aborts reception, releases the pin.
// - Line sampled at 16x baud normally, 8x in double speed.
// - Start bit voted on samples 8,9,10 or 4,5,6; rejected if majority high.
// - Each bit takes 16 or 8 states, decided by majority of centre samples.
// - At the first stop bit the frame moves from shift register to buffer.
// - Unused upper data bits of short frames read as zero.
`timescale 1ns/1ns
module urxbf_top (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset,
  // Oversampling tick from the baud generator, one cycle wide
  input  wire logic                         os_tick,
  // Serial line
  input  wire logic                         serial_rx_pin,
  output logic                              rx_pin_owned,
  // Register port
  input  wire logic [urxbf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [7:0]                        reg_rdata,
  // Interrupt request, gated by the global enable outside
  output logic                              rx_complete_irq
);
  import urxbf_pkg::*;

  logic                 sync1_reg, sync1_next;
  logic                 sync2_reg, sync2_next;
  logic                 line_prev_reg, line_prev_next;
  urxbf_state_t         state_reg, state_next;
  logic [4:0]           samp_reg, samp_next;
  logic [1:0]           votes_reg, votes_next;
  logic [3:0]           bit_idx_reg, bit_idx_next;
  logic [8:0]           shift_reg, shift_next;
  logic                 par_bit_reg, par_bit_next;
  logic                 par_on_reg, par_on_next;
  logic [ENT_W-1:0]     hold_reg, hold_next;
  logic                 hold_valid_reg, hold_valid_next;
  logic                 dor_pend_reg, dor_pend_next;
  logic [ENT_W-1:0]     fifo_reg [2];
  logic [ENT_W-1:0]     fifo_next [2];
  logic                 rd_ptr_reg, rd_ptr_next;
  logic [1:0]           count_reg, count_next;
  logic                 rx_enable_bit_reg, rx_enable_bit_next;
  logic                 rx_complete_irq_en_reg, rx_complete_irq_en_next;
  logic                 u2x_reg, u2x_next;
  logic [2:0]           csz_reg, csz_next;
  logic [1:0]           upm_reg, upm_next;
  logic                 stop_bits_select_reg, stop_bits_select_next;
  logic [7:0]           rdata_reg, rdata_next;

  logic [4:0]           spb;
  logic [4:0]           vote_first;
  logic [4:0]           vote_last;
  logic [3:0]           nbits;
  logic [1:0]           vote_sum;
  logic                 bit_val;
  logic                 rx_complete_flag;
  logic [ENT_W-1:0]     head;
  logic                 pop;
  logic                 par_err;
  logic [ENT_W-1:0]     frame;

  // Gated by the enable so the flag drops in the cycle the disable lands, not one later
  assign rx_complete_flag  = rx_enable_bit_reg && (count_reg != 2'h0);
  assign head = fifo_reg[rd_ptr_reg];
  // Sample rate is set by the tick; double speed only shortens the bit
  assign spb        = u2x_reg ? SPB_DBL : SPB_NORM;
  assign vote_first = u2x_reg ? VOTE_FIRST_DBL : VOTE_FIRST_NORM;
  assign vote_last  = u2x_reg ? VOTE_LAST_DBL : VOTE_LAST_NORM;
  assign nbits      = (csz_reg == CSZ_NINE) ? DATA_BITS_NINE : DATA_BITS_MIN + {2'h0, csz_reg[1:0]};
  assign vote_sum   = votes_reg + {1'b0, sync2_reg};
  assign bit_val    = (vote_sum >= VOTE_MAJORITY);
  assign par_err    = (^shift_reg) ^ par_bit_reg ^ upm_reg[0];

  always_comb begin
    sync1_next      = serial_rx_pin;
    sync2_next      = sync1_reg;
    line_prev_next  = line_prev_reg;
    state_next      = state_reg;
    samp_next       = samp_reg;
    votes_next      = votes_reg;
    bit_idx_next    = bit_idx_reg;
    shift_next      = shift_reg;
    par_bit_next    = par_bit_reg;
    par_on_next     = par_on_reg;
    hold_next       = hold_reg;
    hold_valid_next = hold_valid_reg;
    dor_pend_next   = dor_pend_reg;
    fifo_next[0]    = fifo_reg[0];
    fifo_next[1]    = fifo_reg[1];
    rd_ptr_next     = rd_ptr_reg;
    count_next      = count_reg;
    rx_enable_bit_next       = rx_enable_bit_reg;
    rx_complete_irq_en_next      = rx_complete_irq_en_reg;
    u2x_next        = u2x_reg;
    csz_next        = csz_reg;
    upm_next        = upm_reg;
    stop_bits_select_next       = stop_bits_select_reg;
    rdata_next      = 8'h00;
    frame           = '0;
    pop             = reg_rd && (reg_addr == OFS_DATA) && rx_complete_flag;

    // Register writes; error flag positions are not writable
    if (reg_wr) begin
      case (reg_addr)
        OFS_STATUS_A: begin
          u2x_next = reg_wdata[SA_U2X];
        end
        OFS_CONTROL_B: begin
          rx_complete_irq_en_next  = reg_wdata[CB_RX_COMPLETE_IRQ_EN];
          rx_enable_bit_next   = reg_wdata[CB_RX_ENABLE_BIT];
          csz_next[2] = reg_wdata[CB_CSZ2];
        end
        OFS_CONTROL_C: begin
          upm_next      = {reg_wdata[CC_UPM1], reg_wdata[CC_UPM0]};
          stop_bits_select_next     = reg_wdata[CC_STOP_BITS_SELECT];
          csz_next[1:0] = {reg_wdata[CC_CSZ1], reg_wdata[CC_CSZ0]};
        end
        default: begin
        end
      endcase
    end

    // Register reads; data is answered one cycle later
    if (reg_rd) begin
      case (reg_addr)
        OFS_STATUS_A: begin
          rdata_next[SA_RXC] = rx_complete_flag;
          rdata_next[SA_FE]  = head[ENT_FE] && rx_complete_flag;
          rdata_next[SA_DOR] = head[ENT_DOR] && rx_complete_flag;
          rdata_next[SA_UPE] = head[ENT_UPE] && rx_complete_flag && upm_reg[1];
          rdata_next[SA_U2X] = u2x_reg;
        end
        OFS_CONTROL_B: begin
          rdata_next[CB_RX_COMPLETE_IRQ_EN] = rx_complete_irq_en_reg;
          rdata_next[CB_RX_ENABLE_BIT]  = rx_enable_bit_reg;
          rdata_next[CB_CSZ2]  = csz_reg[2];
          rdata_next[CB_RX_NINTH_BIT]  = head[8] && rx_complete_flag;
        end
        OFS_CONTROL_C: begin
          rdata_next[CC_UPM1] = upm_reg[1];
          rdata_next[CC_UPM0] = upm_reg[0];
          rdata_next[CC_STOP_BITS_SELECT] = stop_bits_select_reg;
          rdata_next[CC_CSZ1] = csz_reg[1];
          rdata_next[CC_CSZ0] = csz_reg[0];
        end
        OFS_DATA: begin
          rdata_next = rx_complete_flag ? head[7:0] : 8'h00;
        end
        default: begin
        end
      endcase
    end

    // Each data read of a non-empty buffer advances data and status together
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
      count_next  = count_reg - 2'h1;
    end

    // Waiting frame enters the buffer as soon as a slot is free
    if (hold_valid_reg && (count_next < FIFO_DEPTH)) begin
      fifo_next[rd_ptr_next ^ count_next[0]] = hold_reg;
      count_next      = count_next + 2'h1;
      hold_valid_next = 1'b0;
    end

    // Receiver runs on the oversampling tick
    if (os_tick) begin
      line_prev_next = sync2_reg;
      case (state_reg)
        ST_IDLE: begin
          if (line_prev_reg && !sync2_reg) begin
            state_next = ST_START;
            samp_next  = 5'h02;                                        // Edge tick is sample 1
            votes_next = 2'h0;
          end
        end
        ST_START, ST_DATA, ST_PAR, ST_STOP: begin
          samp_next = samp_reg + 5'h01;
          if ((samp_reg >= vote_first) && (samp_reg <= vote_last)) begin
            votes_next = vote_sum;
          end
          if (samp_reg == vote_last) begin
            if (state_reg == ST_START) begin
              if (bit_val) begin
                state_next = ST_IDLE;
              end else if (hold_valid_next && (count_next == FIFO_DEPTH)) begin
                dor_pend_next = 1'b1;
              end
              shift_next = 9'h000;
            end else if (state_reg == ST_DATA) begin
              shift_next[bit_idx_reg] = bit_val;
            end else if (state_reg == ST_PAR) begin
              par_bit_next = bit_val;
            end else begin
              // Early return to idle leaves further stop bits unexamined
              frame[8:0]      = shift_reg;
              frame[ENT_FE]   = !bit_val;
              frame[ENT_UPE]  = par_on_reg && par_err;
              frame[ENT_DOR]  = dor_pend_next;
              hold_next       = frame;
              hold_valid_next = 1'b1;
              state_next      = ST_IDLE;
            end
          end
          if (samp_reg == spb) begin
            samp_next  = 5'h01;
            votes_next = 2'h0;
            case (state_reg)
              ST_START: begin
                state_next   = ST_DATA;
                bit_idx_next = 4'h0;
                par_on_next  = upm_reg[1];
              end
              ST_DATA: begin
                bit_idx_next = bit_idx_reg + 4'h1;
                if (bit_idx_reg == nbits - 4'h1) begin
                  state_next = par_on_reg ? ST_PAR : ST_STOP;
                end
              end
              default: begin
                state_next = ST_STOP;
              end
            endcase
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end

    // Overrun mark is delivered with the next frame that enters the buffer
    if (hold_valid_reg && !hold_valid_next) begin
      dor_pend_next = 1'b0;
    end

    // Disable is immediate and discards everything buffered
    if (!rx_enable_bit_reg) begin
      state_next      = ST_IDLE;
      count_next      = 2'h0;
      rd_ptr_next     = 1'b0;
      hold_valid_next = 1'b0;
      dor_pend_next   = 1'b0;
      line_prev_next  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg      <= 1'b1;
      sync2_reg      <= 1'b1;
      line_prev_reg  <= 1'b0;
      state_reg      <= ST_IDLE;
      samp_reg       <= 5'h00;
      votes_reg      <= 2'h0;
      bit_idx_reg    <= 4'h0;
      shift_reg      <= 9'h000;
      par_bit_reg    <= 1'b0;
      par_on_reg     <= 1'b0;
      hold_reg       <= '0;
      hold_valid_reg <= 1'b0;
      dor_pend_reg   <= 1'b0;
      fifo_reg[0]    <= '0;
      fifo_reg[1]    <= '0;
      rd_ptr_reg     <= 1'b0;
      count_reg      <= 2'h0;
      rx_enable_bit_reg       <= 1'b0;
      rx_complete_irq_en_reg      <= 1'b0;
      u2x_reg        <= 1'b0;
      csz_reg        <= 3'h3;
      upm_reg        <= 2'h0;
      stop_bits_select_reg       <= 1'b0;
      rdata_reg      <= 8'h00;
    end else begin
      sync1_reg      <= sync1_next;
      sync2_reg      <= sync2_next;
      line_prev_reg  <= line_prev_next;
      state_reg      <= state_next;
      samp_reg       <= samp_next;
      votes_reg      <= votes_next;
      bit_idx_reg    <= bit_idx_next;
      shift_reg      <= shift_next;
      par_bit_reg    <= par_bit_next;
      par_on_reg     <= par_on_next;
      hold_reg       <= hold_next;
      hold_valid_reg <= hold_valid_next;
      dor_pend_reg   <= dor_pend_next;
      fifo_reg[0]    <= fifo_next[0];
      fifo_reg[1]    <= fifo_next[1];
      rd_ptr_reg     <= rd_ptr_next;
      count_reg      <= count_next;
      rx_enable_bit_reg       <= rx_enable_bit_next;
      rx_complete_irq_en_reg      <= rx_complete_irq_en_next;
      u2x_reg        <= u2x_next;
      csz_reg        <= csz_next;
      upm_reg        <= upm_next;
      stop_bits_select_reg       <= stop_bits_select_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign reg_rdata       = rdata_reg;
  assign rx_pin_owned    = rx_enable_bit_reg;
  // Only the receive-complete flag reaches the interrupt line
  assign rx_complete_irq = rx_complete_irq_en_reg && rx_complete_flag;
endmodule // urxbf_top

// *** verif/urxbf_checker.sv ***
// Assertion checker for the receiver block, bound to its top module
`timescale 1ns/1ns
module urxbf_checker (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         reset,
  // Serial side
  input wire logic                         os_tick,
  input wire logic                         serial_rx_pin,
  input wire logic                         rx_pin_owned,
  // Register port and interrupt
  input wire logic [urxbf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_rdata,
  input wire logic                         rx_complete_irq
);
  import urxbf_pkg::*;
  logic       irq_en_reg;
  logic       irq_en_next;
  logic       par_en_reg;
  logic       par_en_next;
  logic [2:0] csz_reg;
  logic [2:0] csz_next;
  wire logic  pop_or_ctl;
  // Shadow of the control bits the checks depend on
  always_comb begin
    irq_en_next = irq_en_reg;
    par_en_next = par_en_reg;
    csz_next    = csz_reg;
    if (reg_wr && reg_addr == OFS_CONTROL_B) begin
      irq_en_next = reg_wdata[CB_RX_COMPLETE_IRQ_EN];
      csz_next[2] = reg_wdata[CB_CSZ2];
    end
    if (reg_wr && reg_addr == OFS_CONTROL_C) begin
      par_en_next   = reg_wdata[CC_UPM1];
      csz_next[1:0] = reg_wdata[CC_CSZ1:CC_CSZ0];
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_en_reg <= 1'b0;
      par_en_reg <= 1'b0;
      csz_reg    <= 3'h3;
    end else begin
      irq_en_reg <= irq_en_next;
      par_en_reg <= par_en_next;
      csz_reg    <= csz_next;
    end
  end
  // Only a data read or a control B write may end an interrupt request
  assign pop_or_ctl = (reg_rd && reg_addr == OFS_DATA) || (reg_wr && reg_addr == OFS_CONTROL_B);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd(logic [1:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_wr_b;
    reg_wr && reg_addr == OFS_CONTROL_B;
  endsequence
  property p_owned_follows;
    s_wr_b |=> rx_pin_owned == $past(reg_wdata[CB_RX_ENABLE_BIT]);
  endproperty
  a_owned_follows: assert property (p_owned_follows) else $error("pin ownership wrong");
  property p_disable_clears;
    s_wr_b ##0 !reg_wdata[CB_RX_ENABLE_BIT] |=> !rx_complete_irq [*2];
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("irq after disable");
  property p_status_off;
    s_rd(OFS_STATUS_A) ##0 !rx_pin_owned |=>
      {reg_rdata[SA_RXC], reg_rdata[SA_FE], reg_rdata[SA_DOR], reg_rdata[SA_UPE]} == 4'h0;
  endproperty
  a_status_off: assert property (p_status_off) else $error("flags while disabled");
  property p_data_off;
    s_rd(OFS_DATA) ##0 !rx_pin_owned |=> reg_rdata == 8'h00;
  endproperty
  a_data_off: assert property (p_data_off) else $error("data while disabled");
  property p_irq_mirrors;
    s_rd(OFS_STATUS_A) ##0 irq_en_reg |=> reg_rdata[SA_RXC] == $past(rx_complete_irq);
  endproperty
  a_irq_mirrors: assert property (p_irq_mirrors) else $error("irq not equal to flag");
  property p_irq_enable;
    rx_complete_irq |-> irq_en_reg && rx_pin_owned;
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("irq without enable");
  property p_parity_masked;
    s_rd(OFS_STATUS_A) ##0 !par_en_reg |=> !reg_rdata[SA_UPE];
  endproperty
  a_parity_masked: assert property (p_parity_masked) else $error("parity flag set");
  property p_short_upper;
    s_rd(OFS_DATA) ##0 csz_reg == 3'h0 |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_short_upper: assert property (p_short_upper) else $error("upper bits not zero");
  property p_irq_holds;
    $fell(rx_complete_irq) |-> $past(pop_or_ctl);
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("irq dropped unread");
endmodule // urxbf_checker

bind urxbf_top urxbf_checker u_chk (
  .clk(clk), .reset(reset), .os_tick(os_tick), .serial_rx_pin(serial_rx_pin),
  .rx_pin_owned(rx_pin_owned), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_complete_irq(rx_complete_irq)
);

// *** verif/urxbf_tx_model.sv ***
// Behavioural remote serial transmitter driving the receive line
`timescale 1ns/1ns
module urxbf_tx_model (
  // Clock and oversampling tick
  input  wire logic clk,
  input  wire logic os_tick,
  // Serial line, idle high
  output logic      serial_rx_pin
);
  initial serial_rx_pin = 1'b1;
  // Bit 0 goes first; each bit stands spb ticks, so rate matches the receiver exactly
  task automatic send(input logic [12:0] bits, input int spb);
    // Idle ticks first, so a freshly enabled receiver has seen the line high
    repeat (2) begin
      do @(posedge clk); while (os_tick !== 1'b1);
    end
    for (int i = 0; i < 13; i++) begin
      serial_rx_pin <= bits[i];
      repeat (spb) begin
        do @(posedge clk); while (os_tick !== 1'b1);
      end
    end
  endtask
endmodule // urxbf_tx_model

// *** verif/urxbf_tb_top.sv ***
// Self-checking bench for the receiver block: frames, flags and register port
`timescale 1ns/1ns
module urxbf_tb_top;
  import urxbf_pkg::*;
  logic                    clk = 1'b0;
  logic                    reset = 1'b1;
  logic                    os_tick = 1'b0;
  logic                    serial_rx_pin;
  logic                    rx_pin_owned;
  logic                    rx_complete_irq;
  logic [ADDR_W-1:0]       reg_addr = '0;
  logic [7:0]              reg_wdata = 8'h00;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic [7:0]              reg_rdata;
  logic [1:0]              div = 2'h0;
  logic [7:0]              v;
  logic [8:0]              d;
  logic [7:0]              q [4];
  integer                  seed = 13;
  int                      n_fail = 0;
  int                      cmp_count = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  // One tick every four clocks keeps frames short
  always @(posedge clk) begin
    div     <= div + 2'h1;
    os_tick <= (div == 2'h3);
  end
  urxbf_top dut (.clk(clk), .reset(reset), .os_tick(os_tick), .serial_rx_pin(serial_rx_pin),
    .rx_pin_owned(rx_pin_owned), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_complete_irq(rx_complete_irq));
  urxbf_tx_model tx (.clk(clk), .os_tick(os_tick), .serial_rx_pin(serial_rx_pin));
  function automatic logic [12:0] frame(input logic [8:0] dat, input int nd,
                                        input logic pen, input logic podd, input logic stp);
    logic [12:0] f;
    logic        p;
    f = 13'h1ffe;
    p = podd;
    for (int i = 0; i < nd; i++) begin
      f[i+1] = dat[i];
      p      = p ^ dat[i];
    end
    if (pen) begin
      f[nd+1] = p;
    end
    f[nd+1+int'(pen)] = stp;
    return f;
  endfunction
  task automatic wr(input logic [1:0] a, input logic [7:0] w);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] r);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Status and ninth bit are read before the data register pops the entry
  task automatic take(input logic [7:0] st, input logic [7:0] cb, input logic [7:0] dat);
    chk({7'h00, rx_complete_irq}, {7'h00, st[SA_RXC]});
    rd(OFS_STATUS_A, v);
    chk(v, st);
    rd(OFS_CONTROL_B, v);
    chk(v, cb);
    rd(OFS_DATA, v);
    chk(v, dat);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_CONTROL_C, v);
    chk(v, 8'h06);
    rd(OFS_STATUS_A, v);
    chk(v, 8'h00);
    wr(OFS_CONTROL_B, 8'h90);
    chk({7'h00, rx_pin_owned}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CONTROL_C, {5'h00, i[1:0], 1'b0});
      d = 9'($random(seed));
      tx.send(frame(d, i + 5, 1'b0, 1'b0, 1'b1), 16);
      take(8'h80, 8'h90, 8'(d & ((9'h001 << (i + 5)) - 9'h001)));
    end
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CONTROL_C, {2'h0, 1'b1, m[0], 4'h6});
      d = 9'($random(seed));
      tx.send(frame(d, 8, 1'b1, m[0] ^ m[1], 1'b1), 16);
      take({5'h10, m[1], 2'h0}, 8'h90, d[7:0]);
    end
    tx.send(frame(d, 8, 1'b1, 1'b0, 1'b1), 16);
    wr(OFS_CONTROL_C, 8'h06);
    take(8'h80, 8'h90, d[7:0]);
    wr(OFS_CONTROL_B, 8'h94);
    d = 9'($random(seed));
    tx.send(frame(d, 9, 1'b0, 1'b0, 1'b1), 16);
    take(8'h80, {6'h25, d[8], 1'b0}, d[7:0]);
    wr(OFS_CONTROL_B, 8'h90);
    wr(OFS_CONTROL_C, 8'h0e);
    for (int s = 0; s < 2; s++) begin
      d = 9'($random(seed));
      tx.send(frame(d, 8, 1'b0, 1'b0, s[0]), 16);
      take({3'h4, ~s[0], 4'h0}, 8'h90, d[7:0]);
    end
    wr(OFS_CONTROL_C, 8'h06);
    for (int u = 0; u < 2; u++) begin
      wr(OFS_STATUS_A, {6'h00, u[0], 1'b0});
      tx.send(13'h1ffe, 4 >> u);
      rd(OFS_STATUS_A, v);
      chk(v, {6'h00, u[0], 1'b0});
      d = 9'($random(seed));
      tx.send(frame(d, 8, 1'b0, 1'b0, 1'b1), 16 >> u);
      take({6'h20, u[0], 1'b0}, 8'h90, d[7:0]);
    end
    wr(OFS_STATUS_A, 8'h00);
    for (int k = 0; k < 4; k++) begin
      q[k] = 8'($random(seed));
      tx.send(frame({1'b0, q[k]}, 8, 1'b0, 1'b0, 1'b1), 16);
    end
    wr(OFS_STATUS_A, 8'h1c);
    take(8'h80, 8'h90, q[0]);
    take(8'h80, 8'h90, q[1]);
    take(8'h88, 8'h90, q[3]);
    tx.send(frame(d, 8, 1'b0, 1'b0, 1'b1), 16);
    rd(OFS_STATUS_A, v);
    chk(v, 8'h80);
    wr(OFS_CONTROL_B, 8'h80);
    chk({6'h00, rx_pin_owned, rx_complete_irq}, 8'h00);
    take(8'h00, 8'h80, 8'h00);
    wr(OFS_CONTROL_B, 8'h90);
    fork
      tx.send(frame(9'h0a5, 8, 1'b0, 1'b0, 1'b1), 16);
      begin
        repeat (300) @(posedge clk);
        wr(OFS_CONTROL_B, 8'h80);
      end
    join
    wr(OFS_CONTROL_B, 8'h90);
    take(8'h00, 8'h90, 8'h00);
    wrap_up();
  end
endmodule // urxbf_tb_top
